// File: design/fan_output_consts.svh
// Register map, field positions, reset values and timing counts of the fan output block
`ifndef FAN_OUTPUT_CONSTS_SVH
`define FAN_OUTPUT_CONSTS_SVH

`define REG_FREQ1 6'h00
`define REG_VAL1 6'h01
`define REG_FREQ2 6'h02
`define REG_VAL2 6'h03
`define REG_CFG1 6'h04
`define REG_STOPV1 6'h08
`define REG_STOPV2 6'h09
`define REG_START1 6'h0A
`define REG_START2 6'h0B
`define REG_STOPT1 6'h0C
`define REG_STOPT2 6'h0D
`define REG_STEP_DN 6'h0E
`define REG_STEP_UP 6'h0F
`define REG_FREQ3 6'h10
`define REG_VAL3 6'h11
`define REG_CFG2 6'h12
`define REG_STOPV3 6'h15
`define REG_START3 6'h16
`define REG_STOPT3 6'h17
`define REG_TYPE 6'h18
`define REG_DRIVE_BASE 6'h19
`define REG_LAST 6'h1B

`define RST_FREQ 8'h01
`define RST_VAL 8'hFF
`define RST_CFG 8'h00
`define RST_STOPV 8'h01
`define RST_START 8'h01
`define RST_STOPT 8'h3C
`define RST_STEP 8'h0A
`define RST_TYPE 8'h02

`define MASK_CFG1 8'h3C
`define MASK_CFG2 8'h3E
`define MASK_TYPE 8'h07
`define BIT_CLKSEL 7
`define BIT_MODE3_LO 1
`define BIT_FLOOR1 5

`define CLK_HZ 50000000
`define FAST_CLK_HZ 24000000
`define SLOW_CLK_HZ 180000
`define NCO_FAST_INC 32'((64'(`FAST_CLK_HZ) << 32) / `CLK_HZ)
`define NCO_SLOW_INC 32'((64'(`SLOW_CLK_HZ) << 32) / `CLK_HZ)
`define UNIT_PWM_MS 100
`define UNIT_DC_MS 1600
`define TICK_CYCLES ((`CLK_HZ / 1000) * `UNIT_PWM_MS)
`define DC_UNIT_TICKS (`UNIT_DC_MS / `UNIT_PWM_MS)

`endif

// File: design/fan_output_pkg.sv
// Types of the fan output block
`default_nettype none
package fan_output_pkg;
    localparam int NCH = 3;

    typedef enum logic [1:0]
    {
        MODE_MANUAL = 2'h0,
        MODE_THERMAL = 2'h1,
        MODE_SPEED = 2'h2,
        MODE_NONE = 2'h3
    } mode_t;

    typedef struct packed {
        logic [24:0][7:0] regs;
        logic ack;
        logic [7:0] rdat;
        logic [31:0] nco_fast;
        logic [31:0] nco_slow;
        logic [31:0] tick_cnt;
        logic [3:0] unit16;
        logic [NCH-1:0][7:0] val;
        logic [NCH-1:0][8:0] up_cnt;
        logic [NCH-1:0][8:0] dn_cnt;
        logic [NCH-1:0][8:0] stop_cnt;
        logic [NCH-1:0][6:0] pre;
        logic [NCH-1:0][7:0] per;
        logic [NCH-1:0] pwm;
        logic [NCH-1:0][3:0] level;
    } state_t;
endpackage
`default_nettype wire

// File: design/fan_output_cruise_control.sv
// Three-channel fan drive: register file, cruise stepping, PWM and DC level outputs
`include "fan_output_consts.svh"
`default_nettype none
module fan_output_cruise_control #(
    parameter int TICK_CYCLES = `TICK_CYCLES
)(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cyc_in,
    input wire logic stb_in,
    input wire logic we_in,
    input wire logic [7:0] adr_in,
    input wire logic [3:0] sel_in,
    input wire logic [31:0] dat_in,
    input wire logic [2:0] raise_in,
    input wire logic [2:0] lower_in,
    output logic ack_out,
    output logic [31:0] dat_out,
    output logic [2:0] pwm_out,
    output logic [11:0] level_out
);
    // A unit tick needs at least two clocks between wraps of the tick counter
    if (TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    localparam logic [2:0][5:0] FREQ_IX = {`REG_FREQ3, `REG_FREQ2, `REG_FREQ1};
    localparam logic [2:0][5:0] VAL_IX = {`REG_VAL3, `REG_VAL2, `REG_VAL1};
    localparam logic [2:0][5:0] STOPV_IX = {`REG_STOPV3, `REG_STOPV2, `REG_STOPV1};
    localparam logic [2:0][5:0] START_IX = {`REG_START3, `REG_START2, `REG_START1};
    localparam logic [2:0][5:0] STOPT_IX = {`REG_STOPT3, `REG_STOPT2, `REG_STOPT1};

    function automatic logic [7:0] reset_value(input logic [5:0] ix);
        logic [7:0] v;
        v = 8'h00;
        case (ix)
            `REG_FREQ1, `REG_FREQ2, `REG_FREQ3: v = `RST_FREQ;
            `REG_VAL1, `REG_VAL2, `REG_VAL3: v = `RST_VAL;
            `REG_STOPV1, `REG_STOPV2, `REG_STOPV3: v = `RST_STOPV;
            `REG_START1, `REG_START2, `REG_START3: v = `RST_START;
            `REG_STOPT1, `REG_STOPT2, `REG_STOPT3: v = `RST_STOPT;
            `REG_STEP_DN, `REG_STEP_UP: v = `RST_STEP;
            `REG_TYPE: v = `RST_TYPE;
            default: v = `RST_CFG;
        endcase
        return v;
    endfunction

    // Holes in the map are not stored, read as zero and ignore writes
    function automatic logic stored(input logic [5:0] ix);
        return ix <= `REG_TYPE && !(ix >= 6'h05 && ix <= 6'h07) && ix != 6'h13 && ix != 6'h14;
    endfunction

    function automatic logic [7:0] write_mask(input logic [5:0] ix);
        logic [7:0] m;
        m = 8'hFF;
        if (ix == `REG_CFG1)
        begin
            m = `MASK_CFG1;
        end
        else if (ix == `REG_CFG2)
        begin
            m = `MASK_CFG2;
        end
        else if (ix == `REG_TYPE)
        begin
            m = `MASK_TYPE;
        end
        return m;
    endfunction

    function automatic fan_output_pkg::state_t init_state();
        fan_output_pkg::state_t s;
        s = '0;
        for (int i = 0; i < 25; i++)
        begin
            s.regs[i] = reset_value(6'(i));
        end
        for (int g = 0; g < fan_output_pkg::NCH; g++)
        begin
            s.val[g] = `RST_VAL;
        end
        return s;
    endfunction

    localparam fan_output_pkg::state_t RESET_STATE = init_state();

    fan_output_pkg::state_t s_q;
    fan_output_pkg::state_t s_d;

    logic req;
    logic wr;
    logic [5:0] ix;
    logic [32:0] fast_sum;
    logic [32:0] slow_sum;
    logic tick;
    logic dc_tick;
    logic unit_tick;
    logic step_restart;
    logic [7:0] stopv;
    logic [7:0] div_m1;
    logic [7:0] freq;
    fan_output_pkg::mode_t mode;
    logic floor_hold;
    logic is_pwm;

    always_comb
    begin
        s_d = s_q;
        req = cyc_in && stb_in && !s_q.ack;
        // A write lands at the ack edge, where the master still holds address and data
        wr = cyc_in && stb_in && s_q.ack && we_in && sel_in[0];
        ix = adr_in[7:2];
        fast_sum = {1'b0, s_q.nco_fast} + {1'b0, `NCO_FAST_INC};
        slow_sum = {1'b0, s_q.nco_slow} + {1'b0, `NCO_SLOW_INC};
        tick = s_q.tick_cnt == 32'(TICK_CYCLES - 1);
        dc_tick = tick && s_q.unit16 == 4'(`DC_UNIT_TICKS - 1);
        unit_tick = 1'b0;
        step_restart = wr && (ix == `REG_STEP_DN || ix == `REG_STEP_UP);
        stopv = 8'h00;
        div_m1 = 8'h00;
        freq = 8'h00;
        mode = fan_output_pkg::MODE_MANUAL;
        floor_hold = 1'b0;
        is_pwm = 1'b0;

        // Classic single-cycle slave: one wait state, ack drops the cycle after
        s_d.ack = req;
        if (req)
        begin
            if (stored(ix))
            begin
                s_d.rdat = s_q.regs[ix[4:0]];
            end
            else if (ix >= `REG_DRIVE_BASE && ix <= `REG_LAST)
            begin
                s_d.rdat = s_q.val[2'(ix - `REG_DRIVE_BASE)];
            end
            else
            begin
                s_d.rdat = 8'h00;
            end
        end
        if (wr && stored(ix))
        begin
            s_d.regs[ix[4:0]] = dat_in[7:0] & write_mask(ix);
        end

        s_d.nco_fast = fast_sum[31:0];
        s_d.nco_slow = slow_sum[31:0];
        s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;
        if (tick)
        begin
            s_d.unit16 = s_q.unit16 + 4'h1;
        end

        for (int g = 0; g < fan_output_pkg::NCH; g++)
        begin
            is_pwm = s_q.regs[`REG_TYPE][g];
            unit_tick = is_pwm ? tick : dc_tick;
            stopv = s_q.regs[STOPV_IX[g]];
            if (g == 2)
            begin
                mode = fan_output_pkg::mode_t'(
                    s_q.regs[`REG_CFG2][`BIT_MODE3_LO +: 2]);
            end
            else
            begin
                mode = fan_output_pkg::mode_t'(s_q.regs[`REG_CFG1][2 * g + 2 +: 2]);
            end
            floor_hold = s_q.regs[`REG_CFG2][`BIT_FLOOR1 - g];

            if (mode == fan_output_pkg::MODE_THERMAL || mode == fan_output_pkg::MODE_SPEED)
            begin
                if (raise_in[g])
                begin
                    s_d.dn_cnt[g] = 9'h000;
                    s_d.stop_cnt[g] = 9'h000;
                    if (s_q.val[g] == 8'h00)
                    begin
                        // A stalled fan needs a kick, not a slow ramp
                        s_d.val[g] = s_q.regs[START_IX[g]];
                        s_d.up_cnt[g] = 9'h000;
                    end
                    else if (unit_tick)
                    begin
                        if (s_q.up_cnt[g] + 9'h001 >= {1'b0, s_q.regs[`REG_STEP_UP]})
                        begin
                            s_d.up_cnt[g] = 9'h000;
                            if (s_q.val[g] != 8'hFF)
                            begin
                                s_d.val[g] = s_q.val[g] + 8'h01;
                            end
                        end
                        else
                        begin
                            s_d.up_cnt[g] = s_q.up_cnt[g] + 9'h001;
                        end
                    end
                end
                else if (lower_in[g])
                begin
                    s_d.up_cnt[g] = 9'h000;
                    if (s_q.val[g] > stopv)
                    begin
                        s_d.stop_cnt[g] = 9'h000;
                        if (unit_tick)
                        begin
                            if (s_q.dn_cnt[g] + 9'h001 >= {1'b0, s_q.regs[`REG_STEP_DN]})
                            begin
                                s_d.dn_cnt[g] = 9'h000;
                                s_d.val[g] = s_q.val[g] - 8'h01;
                            end
                            else
                            begin
                                s_d.dn_cnt[g] = s_q.dn_cnt[g] + 9'h001;
                            end
                        end
                    end
                    else if (!floor_hold && s_q.val[g] != 8'h00 && unit_tick)
                    begin
                        // At the floor: wait out the stop time, then switch off
                        if (s_q.stop_cnt[g] + 9'h001 >= {1'b0, s_q.regs[STOPT_IX[g]]})
                        begin
                            s_d.stop_cnt[g] = 9'h000;
                            s_d.val[g] = 8'h00;
                        end
                        else
                        begin
                            s_d.stop_cnt[g] = s_q.stop_cnt[g] + 9'h001;
                        end
                    end
                end
                else
                begin
                    s_d.up_cnt[g] = 9'h000;
                    s_d.dn_cnt[g] = 9'h000;
                    s_d.stop_cnt[g] = 9'h000;
                end
            end
            else if (mode == fan_output_pkg::MODE_MANUAL)
            begin
                s_d.val[g] = s_q.regs[VAL_IX[g]];
                s_d.up_cnt[g] = 9'h000;
                s_d.dn_cnt[g] = 9'h000;
                s_d.stop_cnt[g] = 9'h000;
            end

            if (step_restart)
            begin
                s_d.up_cnt[g] = 9'h000;
                s_d.dn_cnt[g] = 9'h000;
            end
            if (wr && ix == STOPT_IX[g])
            begin
                s_d.stop_cnt[g] = 9'h000;
            end

            // Prescale then a 256-count period; a zero divisor wraps to 128
            freq = s_q.regs[FREQ_IX[g]];
            div_m1 = {1'b0, freq[6:0] - 7'h01};
            if (freq[`BIT_CLKSEL] ? slow_sum[32] : fast_sum[32])
            begin
                if ({1'b0, s_q.pre[g]} >= div_m1)
                begin
                    s_d.pre[g] = 7'h00;
                    s_d.per[g] = s_q.per[g] + 8'h01;
                end
                else
                begin
                    s_d.pre[g] = s_q.pre[g] + 7'h01;
                end
            end
            // A 256-count period cannot hit value/255 exactly; ends are exact
            s_d.pwm[g] = is_pwm &&
                (s_q.val[g] == 8'hFF || s_q.per[g] < s_q.val[g]);
            s_d.level[g] = is_pwm ? 4'h0 : s_q.val[g][7:4];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_q <= RESET_STATE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign ack_out = s_q.ack;
    assign dat_out = {24'h00_0000, s_q.rdat};
    assign pwm_out = s_q.pwm;
    assign level_out = s_q.level;
endmodule
`default_nettype wire

// File: tb/fan_output_cruise_control_chk.sv
// Port-level checks of the fan output block, bound to its top module
`default_nettype none
module fan_output_cruise_control_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cyc_in,
    input wire logic stb_in,
    input wire logic we_in,
    input wire logic [7:0] adr_in,
    input wire logic [3:0] sel_in,
    input wire logic [31:0] dat_in,
    input wire logic [2:0] raise_in,
    input wire logic [2:0] lower_in,
    input wire logic ack_out,
    input wire logic [31:0] dat_out,
    input wire logic [2:0] pwm_out,
    input wire logic [11:0] level_out
);
    logic [7:0] type_q;
    logic [7:0] cfg_q;
    logic [7:0] val_q;
    logic [2:0] quiet_q;
    logic wr;
    logic man;
    assign wr = cyc_in && stb_in && we_in && sel_in[0] && ack_out;
    // Compare only once the two-stage drive path has settled after a write
    assign man = quiet_q == 3'h7 && cfg_q[2:1] == 2'h0;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            type_q <= 8'h02;
            cfg_q <= 8'h00;
            val_q <= 8'hFF;
            quiet_q <= 3'h0;
        end
        else
        begin
            if (wr && adr_in[7:2] == 6'h18)
                type_q <= dat_in[7:0];
            if (wr && adr_in[7:2] == 6'h12)
                cfg_q <= dat_in[7:0];
            if (wr && adr_in[7:2] == 6'h11)
                val_q <= dat_in[7:0];
            quiet_q <= wr ? 3'h0 : quiet_q + 3'(quiet_q != 3'h7);
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_ack_pulse: assert property (ack_out |=> !ack_out) else $error("ack too long");
    chk_ack_next: assert property (cyc_in && stb_in && !ack_out |=> ack_out)
        else $error("request not answered next cycle");
    chk_ack_cause: assert property (ack_out |-> $past(cyc_in && stb_in))
        else $error("ack without request");
    chk_idle_no_ack: assert property (!(cyc_in && stb_in) |=> !ack_out)
        else $error("ack while idle");
    chk_read_upper: assert property (ack_out |-> dat_out[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    chk_type_excl:
        assert property (pwm_out[2] |-> level_out[11:8] == 4'h0) else $error("both outputs on");
    chk_dc_code:
        assert property (man && !type_q[2] |-> level_out[11:8] == val_q[7:4] && !pwm_out[2])
        else $error("level code wrong");
    chk_full_duty:
        assert property (man && type_q[2] && val_q == 8'hFF |-> pwm_out[2] [*2])
        else $error("full duty not high");
    chk_zero_duty:
        assert property (man && type_q[2] && val_q == 8'h00 |-> !pwm_out[2] [*2])
        else $error("zero duty not low");
endmodule
bind fan_output_cruise_control fan_output_cruise_control_chk i_fan_output_cruise_control_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cyc_in(cyc_in), .stb_in(stb_in),
    .we_in(we_in), .adr_in(adr_in), .sel_in(sel_in), .dat_in(dat_in),
    .raise_in(raise_in), .lower_in(lower_in), .ack_out(ack_out), .dat_out(dat_out),
    .pwm_out(pwm_out), .level_out(level_out));
`default_nettype wire

// File: tb/fan_pre_driver_model.sv
// Fan pre-driver model: measures high time and pulses of one drive pin
`default_nettype none
module fan_pre_driver_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic drive_in,
    input wire logic clear_in,
    output logic [15:0] high_out,
    output logic [15:0] total_out,
    output logic [15:0] rise_out
);
    logic prev_q;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            high_out <= 16'h0000;
            total_out <= 16'h0000;
            rise_out <= 16'h0000;
            prev_q <= 1'b0;
        end
        else if (clear_in)
        begin
            // Take the pin level as it stands, so a steady high is not a rise
            high_out <= 16'h0000;
            total_out <= 16'h0000;
            rise_out <= 16'h0000;
            prev_q <= drive_in;
        end
        else
        begin
            total_out <= total_out + 16'h0001;
            high_out <= high_out + 16'(drive_in);
            rise_out <= rise_out + 16'(drive_in && !prev_q);
            prev_q <= drive_in;
        end
    end
endmodule
`default_nettype wire

// File: tb/fan_output_cruise_control_bench.sv
// Self-checking bench of the fan output block with a register model
`default_nettype none
module fan_output_cruise_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 20;
    logic clk_in = 0, rst_n_in = 0, cyc_in = 0, stb_in = 0, we_in = 0, clr = 0;
    logic [7:0] adr_in = 0;
    logic [3:0] sel_in = 0;
    logic [31:0] dat_in = 0;
    logic [2:0] raise_in = 0, lower_in = 0;
    logic ack_out;
    logic [31:0] dat_out;
    logic [2:0] pwm_out;
    logic [11:0] level_out;
    logic [15:0] high, total, rise;
    logic [7:0] q, v, d1;
    int err_total = 0, compares = 0, seed = 63450;
    int exp_reg[int];
    always #10 clk_in = ~clk_in;
    fan_output_cruise_control #(.TICK_CYCLES(TICK)) i_fan_output_cruise_control (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cyc_in(cyc_in), .stb_in(stb_in),
        .we_in(we_in), .adr_in(adr_in), .sel_in(sel_in), .dat_in(dat_in),
        .raise_in(raise_in), .lower_in(lower_in), .ack_out(ack_out), .dat_out(dat_out),
        .pwm_out(pwm_out), .level_out(level_out));
    fan_pre_driver_model i_fan_pre_driver_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .drive_in(pwm_out[2]), .clear_in(clr), .high_out(high), .total_out(total),
        .rise_out(rise));
    task automatic give_verdict;
        $display("Compares %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc_in <= 1;
        stb_in <= 1;
        we_in <= w;
        adr_in <= {idx, 2'b00};
        dat_in <= {24'h00_0000, d};
        sel_in <= 4'hF;
        // Request is held until ack is sampled, for at most 50 cycles
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (ack_out !== 1'b1 && n < 50);
        if (ack_out !== 1'b1)
        begin
            err_total++;
            give_verdict();
        end
        q = dat_out[7:0];
        cyc_in <= 0;
        stb_in <= 0;
    endtask
    task automatic wr(input int idx, input logic [7:0] d);
        wb(1'b1, 6'(idx), d);
        if (exp_reg.exists(idx))
            exp_reg[idx] = d & (idx == 'h12 ? 8'h3E : 8'hFF);
    endtask
    task automatic rd(input int idx);
        wb(1'b0, 6'(idx), 8'h00);
        check($sformatf("reg %h", idx), q, exp_reg.exists(idx) ? exp_reg[idx] : 0);
    endtask
    task automatic drv(input logic [7:0] e);
        wb(1'b0, 6'h1B, 8'h00);
        check("drive", q, e);
    endtask
    task automatic measure(input logic [7:0] val, input int lo, input int hi);
        wr('h11, val);
        @(posedge clk_in);
        clr <= 1;
        @(posedge clk_in);
        clr <= 0;
        repeat (5333) @(posedge clk_in);
        check("rises", rise >= lo && rise <= hi, 1);
    endtask
    initial
    begin
        exp_reg = '{'h0C:'h3C, 'h0D:'h3C, 'h0E:'h0A, 'h0F:'h0A, 'h10:'h01, 'h11:'hFF,
            'h12:'h00, 'h15:'h01, 'h16:'h01, 'h17:'h3C};
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1;
        foreach (exp_reg[i])
            rd(i);
        rd('h05);
        foreach (exp_reg[i])
        begin
            // Divisor and stop value are kept non-zero
            v = 8'($random(seed)) | 8'(i == 'h10 || i == 'h15);
            wr(i, v);
            rd(i);
        end
        wr('h05, 8'hA5);
        rd('h05);
        wr('h12, 8'h00);
        repeat (4)
        begin
            v = 8'($random(seed));
            wr('h11, v);
            repeat (4) @(posedge clk_in);
            check("level", level_out[11:8], v[7:4]);
            check("pwm off", pwm_out[2], 0);
        end
        wr('h18, 8'h04);
        wr('h10, 8'h01);
        measure(8'h80, 9, 11);
        check("duty", (32'(high) * 256 / total) inside {[112:144]}, 1);
        measure(8'hFF, 0, 1);
        check("full", high, total);
        measure(8'h00, 0, 0);
        check("zero", high, 0);
        wr('h10, 8'h02);
        measure(8'h80, 4, 6);
        wr('h10, 8'h81);
        measure(8'h80, 0, 1);
        wr('h0E, 8'h02);
        wr('h0F, 8'h02);
        wr('h17, 8'h03);
        wr('h15, 8'h10);
        wr('h16, 8'h40);
        wr('h11, 8'h14);
        wr('h12, 8'h0A);
        lower_in <= 3'b100;
        repeat (8) @(posedge clk_in);
        drv(8'h14);
        repeat (35) @(posedge clk_in);
        drv(8'h13);
        repeat (400) @(posedge clk_in);
        drv(8'h10);
        wr('h12, 8'h02);
        wr('h17, 8'h03);
        repeat (20) @(posedge clk_in);
        drv(8'h10);
        repeat (50) @(posedge clk_in);
        drv(8'h00);
        lower_in <= 3'b000;
        raise_in <= 3'b100;
        repeat (5) @(posedge clk_in);
        drv(8'h40);
        repeat (400) @(posedge clk_in);
        wb(1'b0, 6'h1B, 8'h00);
        check("rise pace", q inside {[8'h48:8'h4B]}, 1);
        wr('h18, 8'h00);
        wb(1'b0, 6'h1B, 8'h00);
        d1 = q;
        repeat (1300) @(posedge clk_in);
        wb(1'b0, 6'h1B, 8'h00);
        check("dc pace", (q - d1) inside {[8'h01:8'h03]}, 1);
        raise_in <= 3'b000;
        wb(1'b0, 6'h1B, 8'h00);
        d1 = q;
        wr('h12, 8'h06);
        wr('h11, 8'h22);
        repeat (4) @(posedge clk_in);
        drv(d1);
        wr('h12, 8'h00);
        repeat (4) @(posedge clk_in);
        drv(8'h22);
        wr('h12, 8'h04);
        lower_in <= 3'b100;
        repeat (1400) @(posedge clk_in);
        wb(1'b0, 6'h1B, 8'h00);
        check("speed pace", (8'h22 - q) inside {[8'h01:8'h03]}, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
